// File: hdl/rsq_top.sv
// reset and stop-mode sequencer with its power control and reset cause registers
// assumes an Avalon-MM master on the register side and synchronous pin inputs
//
// How it works
// R1: a stop write halts cpu and oscillator from the next cycle.
// R2: only a reset leaves stop; boot then fetches from 0x0000.
// R3: software powers down analog blocks itself before stopping.
// R4: software disables the clock detector before long stops.
// R5: reset halts execution, loads register defaults, disables interrupts and timers.
// R6: reset leaves data memory alone; the stack pointer is reloaded with the other registers.
// R7: port latches are loaded with all ones during reset.
// R8: after reset: pc cleared, slow internal clock, watchdog longest, then run.
// R9: supply monitor drives reset pin low until its 100 ms timeout ends.
// R10: power-on flag reads 1 after power-on; other resets clear it.
// R11: low supply holds reset via the pin; recovery behaves like power-on.
// R12: reset pin low resets; held 12 cycles after release; pin flag set.
// R13: a clock gap over 100 us resets without the pin; flag bit 2.
// R14: writing bit 2 of the cause register enables the clock detector.
// R15: with bit 5 enabled, comparator below resets; flag bit 5; pin untouched.
// R16: software enables the comparator before enabling its reset.
// R17: with bit 6 enabled, convert start low resets; flag bit 6.
// R18: software routes convert start to a pin before enabling it.
// R19: in idle an interrupt clears idle and resumes the cpu.
// R20: stop and idle bits always read back as zero.
`timescale 1ns/1ps
`include "rsq_params.svh"
module rsq_top #(
  parameter int SUPPLY_CYCLES = `RSQ_SUPPLY_TIMEOUT_MS * (`RSQ_CLK_HZ / 1000)
) (
  input  wire logic        REF_CLK_IN,
  input  wire logic        RESETN_IN,
  input  wire logic [9:0]  AVS_ADDRESS_IN,
  input  wire logic        AVS_READ_IN,
  input  wire logic        AVS_WRITE_IN,
  input  wire logic [31:0] AVS_WRITEDATA_IN,
  input  wire logic [3:0]  AVS_BYTEENABLE_IN,
  output logic      [31:0] AVS_READDATA_OUT,
  output logic             AVS_WAITREQUEST_OUT,
  input  wire logic        SUPPLY_OK_IN,
  input  wire logic        SUPPLY_MONITOR_ENABLE_PIN_IN,
  input  wire logic        RST_PIN_IN,
  output logic             RST_PIN_OUT,
  output logic             RST_PIN_OE_OUT,
  input  wire logic        SYSCLK_TICK_IN,
  input  wire logic [7:0]  COMPARATOR_NONINVERTING_INPUT_IN,
  input  wire logic [7:0]  COMPARATOR_INVERTING_INPUT_IN,
  input  wire logic        CONVERT_START_INPUT_IN,
  input  wire logic        OSC_STABLE_IN,
  input  wire logic        IRQ_PENDING_IN,
  output logic             CORE_RESET_OUT,
  output logic             CPU_HALT_OUT,
  output logic             OSC_ENABLE_OUT,
  output logic             OSC_DEFAULT_OUT,
  output logic             PORT_LATCH_LOAD_OUT,
  output logic      [7:0]  PORT_LATCH_VALUE_OUT,
  output logic             PC_LOAD_OUT,
  output logic      [15:0] FETCH_ADDR_OUT,
  output logic             WDT_ENABLE_OUT,
  output logic      [2:0]  WDT_INTERVAL_OUT,
  output logic             IDLE_WAKE_OUT
);
  rsq_src_if src_sig ();

  rsq_pkg::rsq_state_t state;
  rsq_pkg::rsq_state_t next_state;
  rsq_pkg::rsq_byte_t  power_control_upper;
  rsq_pkg::rsq_byte_t  next_power_control_upper;
  rsq_pkg::rsq_byte_t  cause_flags;
  rsq_pkg::rsq_byte_t  next_cause_flags;
  rsq_pkg::rsq_byte_t  rd_byte;
  rsq_pkg::rsq_byte_t  fresh_causes;
  logic        cmp_en;
  logic        next_cmp_en;
  logic        cnv_en;
  logic        next_cnv_en;
  logic        mcd_en;
  logic        next_mcd_en;
  logic [31:0] next_readdata;
  logic        next_waitreq;
  logic        sel_power_control;
  logic        sel_cause;
  logic        wr_fire;
  logic        cmp_fire;
  logic        cnv_fire;
  logic        any_reset;
  logic        next_core_reset;
  logic        next_halt;
  logic        next_osc_en;
  logic        next_pc_load;
  logic        next_idle_wake;
  logic        next_pin_oe;

  rsq_src #(
    .SUPPLY_CYCLES (SUPPLY_CYCLES)
  ) u_src (
    .clk_in         (REF_CLK_IN),
    .rst_n_in       (RESETN_IN),
    .supply_ok_in   (SUPPLY_OK_IN),
    .monitor_en_in  (SUPPLY_MONITOR_ENABLE_PIN_IN),
    .rst_pin_in     (RST_PIN_IN),
    .pin_driven_in  (RST_PIN_OE_OUT),
    .sysclk_tick_in (SYSCLK_TICK_IN),
    .sig            (src_sig)
  );

  assign src_sig.mcd_en  = mcd_en;
  assign src_sig.osc_run = OSC_ENABLE_OUT;

  // bus answer: one wait cycle, then waitrequest low for exactly one cycle
  always_comb begin
    sel_power_control  = AVS_ADDRESS_IN[9:2] == `RSQ_IDX_POWER_CONTROL;
    sel_cause = AVS_ADDRESS_IN[9:2] == `RSQ_IDX_RESET_CAUSE;
    rd_byte   = 8'h00;
    if (sel_power_control) begin
      rd_byte = {power_control_upper[7:2], 2'b00}; // R20
    end else if (sel_cause) begin
      rd_byte = cause_flags;
    end
    next_waitreq  = !((AVS_READ_IN || AVS_WRITE_IN) && AVS_WAITREQUEST_OUT);
    next_readdata = AVS_READDATA_OUT;
    if (AVS_READ_IN && AVS_WAITREQUEST_OUT) begin
      next_readdata = {24'h000000, rd_byte};
    end
  end

  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      AVS_WAITREQUEST_OUT <= 1'b1;
      AVS_READDATA_OUT    <= 32'h00000000;
    end else begin
      AVS_WAITREQUEST_OUT <= next_waitreq;
      AVS_READDATA_OUT    <= next_readdata;
    end
  end

  // sequencer core
  always_comb begin
    // writes land on the edge where waitrequest is low; reset holds the registers
    wr_fire = AVS_WRITE_IN && !AVS_WAITREQUEST_OUT && AVS_BYTEENABLE_IN[0] && state != rsq_pkg::ST_RESET;
    cmp_fire = cmp_en && (COMPARATOR_NONINVERTING_INPUT_IN < COMPARATOR_INVERTING_INPUT_IN); // R15
    cnv_fire = cnv_en && !CONVERT_START_INPUT_IN; // R17
    any_reset = src_sig.supply_hold || src_sig.pin_hold || src_sig.mcd_fire || cmp_fire || cnv_fire; // R2

    fresh_causes = 8'h00;
    fresh_causes[`RSQ_BIT_POR] = src_sig.supply_hold; // R11
    fresh_causes[`RSQ_BIT_PIN] = src_sig.pin_hold && !src_sig.supply_hold; // R12
    fresh_causes[`RSQ_BIT_MCD] = src_sig.mcd_fire; // R13
    fresh_causes[`RSQ_BIT_CMP] = cmp_fire; // R15
    fresh_causes[`RSQ_BIT_CNV] = cnv_fire; // R17

    next_state       = state;
    next_power_control_upper  = power_control_upper;
    next_cause_flags = cause_flags;
    next_mcd_en      = mcd_en;
    next_cmp_en      = cmp_en;
    next_cnv_en      = cnv_en;
    next_pc_load     = 1'b0;
    next_idle_wake   = 1'b0;

    if (wr_fire && sel_power_control) begin
      next_power_control_upper = {AVS_WRITEDATA_IN[7:2], 2'b00};
    end
    if (wr_fire && sel_cause) begin
      next_mcd_en = AVS_WRITEDATA_IN[`RSQ_BIT_MCD]; // R14
      next_cmp_en = AVS_WRITEDATA_IN[`RSQ_BIT_CMP]; // R15
      next_cnv_en = AVS_WRITEDATA_IN[`RSQ_BIT_CNV]; // R17
    end

    unique case (state)
      rsq_pkg::ST_RESET: begin
        if (!any_reset) begin
          next_state = rsq_pkg::ST_BOOT;
        end
      end
      rsq_pkg::ST_BOOT: begin
        // execution waits for a stable clock before the first fetch
        if (OSC_STABLE_IN) begin
          next_state   = rsq_pkg::ST_RUN;
          next_pc_load = 1'b1; // R8
        end
      end
      rsq_pkg::ST_RUN: begin
        if (wr_fire && sel_power_control && AVS_WRITEDATA_IN[`RSQ_BIT_STOP]) begin
          next_state = rsq_pkg::ST_STOP; // R1
        end else if (wr_fire && sel_power_control && AVS_WRITEDATA_IN[`RSQ_BIT_IDLE]) begin
          next_state = rsq_pkg::ST_IDLE;
        end
      end
      rsq_pkg::ST_IDLE: begin
        if (IRQ_PENDING_IN) begin
          next_state     = rsq_pkg::ST_RUN; // R19
          next_idle_wake = 1'b1;
        end
      end
      rsq_pkg::ST_STOP: begin
        next_state = rsq_pkg::ST_STOP; // R2
      end
    endcase

    if (any_reset) begin
      next_state      = rsq_pkg::ST_RESET; // R5
      next_power_control_upper = `RSQ_POWER_CONTROL_RESET;
      next_mcd_en     = 1'b0;
      next_cmp_en     = 1'b0;
      next_cnv_en     = 1'b0;
      next_pc_load    = 1'b0;
      next_idle_wake  = 1'b0;
      // a new episode replaces the flags, a running one gathers further causes
      if (state != rsq_pkg::ST_RESET) begin
        next_cause_flags = fresh_causes; // R10
      end else begin
        next_cause_flags = cause_flags | fresh_causes;
        next_cause_flags[`RSQ_BIT_PIN] = fresh_causes[`RSQ_BIT_PIN] | (cause_flags[`RSQ_BIT_PIN] & ~cause_flags[`RSQ_BIT_POR]);
      end
      if (next_cause_flags[`RSQ_BIT_POR]) begin
        next_cause_flags[`RSQ_BIT_PIN] = 1'b0;
      end
    end

    next_core_reset = next_state == rsq_pkg::ST_RESET; // R5
    next_halt       = next_state != rsq_pkg::ST_RUN; // R1
    next_osc_en     = next_state != rsq_pkg::ST_STOP; // R1
    // only the supply monitor pulls the pin; the other sources leave it alone
    next_pin_oe     = src_sig.supply_hold; // R9
  end

  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      state                <= rsq_pkg::ST_RESET;
      power_control_upper           <= `RSQ_POWER_CONTROL_RESET;
      cause_flags          <= `RSQ_CAUSE_AFTER_POR; // R10
      mcd_en               <= 1'b0;
      cmp_en               <= 1'b0;
      cnv_en               <= 1'b0;
      CORE_RESET_OUT       <= 1'b1;
      CPU_HALT_OUT         <= 1'b1;
      OSC_ENABLE_OUT       <= 1'b1;
      OSC_DEFAULT_OUT      <= 1'b1;
      PORT_LATCH_LOAD_OUT  <= 1'b1;
      PORT_LATCH_VALUE_OUT <= `RSQ_PORT_LATCH_RESET;
      PC_LOAD_OUT          <= 1'b0;
      FETCH_ADDR_OUT       <= `RSQ_FETCH_ADDR;
      WDT_ENABLE_OUT       <= 1'b0;
      WDT_INTERVAL_OUT     <= `RSQ_WDT_LONGEST;
      IDLE_WAKE_OUT        <= 1'b0;
      RST_PIN_OUT          <= 1'b0;
      RST_PIN_OE_OUT       <= 1'b1;
    end else begin
      state                <= next_state;
      power_control_upper           <= next_power_control_upper;
      cause_flags          <= next_cause_flags;
      mcd_en               <= next_mcd_en;
      cmp_en               <= next_cmp_en;
      cnv_en               <= next_cnv_en;
      // core reset reloads the stack pointer with the other registers; memory is not cleared
      CORE_RESET_OUT       <= next_core_reset; // R6
      CPU_HALT_OUT         <= next_halt;
      OSC_ENABLE_OUT       <= next_osc_en;
      OSC_DEFAULT_OUT      <= next_core_reset; // R8
      PORT_LATCH_LOAD_OUT  <= next_core_reset; // R7
      PORT_LATCH_VALUE_OUT <= `RSQ_PORT_LATCH_RESET; // R7
      PC_LOAD_OUT          <= next_pc_load; // R8
      FETCH_ADDR_OUT       <= `RSQ_FETCH_ADDR; // R2
      WDT_ENABLE_OUT       <= next_pc_load; // R8
      WDT_INTERVAL_OUT     <= `RSQ_WDT_LONGEST; // R8
      IDLE_WAKE_OUT        <= next_idle_wake; // R19
      RST_PIN_OUT          <= 1'b0;
      RST_PIN_OE_OUT       <= next_pin_oe; // R9
    end
  end
endmodule // rsq_top

// File: common/rsq_params.svh
// constants of the reset and stop-mode sequencer: offsets, bit positions,
// reset values and timing figures; included by the design files by bare name
`ifndef RSQ_PARAMS_SVH
`define RSQ_PARAMS_SVH

`define RSQ_CLK_HZ              25000000
`define RSQ_SUPPLY_TIMEOUT_MS   100
`define RSQ_MCD_TIMEOUT_US      100
`define RSQ_PIN_STRETCH_CYCLES  4'hc

`define RSQ_IDX_POWER_CONTROL   8'h87
`define RSQ_IDX_RESET_CAUSE     8'hef
`define RSQ_POWER_CONTROL_RESET 8'h00
`define RSQ_RESET_CAUSE_RESET   8'h00
`define RSQ_CAUSE_AFTER_POR     8'h02

`define RSQ_BIT_IDLE            0
`define RSQ_BIT_STOP            1
`define RSQ_BIT_PIN             0
`define RSQ_BIT_POR             1
`define RSQ_BIT_MCD             2
`define RSQ_BIT_CMP             5
`define RSQ_BIT_CNV             6

`define RSQ_FETCH_ADDR          16'h0000
`define RSQ_PORT_LATCH_RESET    8'hff
`define RSQ_WDT_LONGEST         3'h7

`endif

// File: common/rsq_pkg.sv
// types used by the sequencer top: its state encoding and byte type
package rsq_pkg;

  typedef enum logic [2:0] {
    ST_RESET,
    ST_BOOT,
    ST_RUN,
    ST_IDLE,
    ST_STOP
  } rsq_state_t;

  typedef logic [7:0] rsq_byte_t;

endpackage

// File: common/rsq_src_if.sv
// carrier between the sequencer top and the reset source timers
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface rsq_src_if;
  logic mcd_en;
  logic osc_run;
  logic supply_hold;
  logic pin_hold;
  logic mcd_fire;

  modport core (output mcd_en, output osc_run, input supply_hold, input pin_hold, input mcd_fire);
  modport src  (input mcd_en, input osc_run, output supply_hold, output pin_hold, output mcd_fire);
endinterface

// File: hdl/rsq_src.sv
// reset source timers: supply monitor timeout, reset pin stretch, missing clock detector
// assumes synchronous inputs and that the top owns the pin drivers
`timescale 1ns/1ps
`include "rsq_params.svh"
module rsq_src #(
  parameter int SUPPLY_CYCLES = 2500000
) (
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  input  wire logic supply_ok_in,
  input  wire logic monitor_en_in,
  input  wire logic rst_pin_in,
  input  wire logic pin_driven_in,
  input  wire logic sysclk_tick_in,
  rsq_src_if.src    sig
);
  localparam logic [21:0] SUPPLY_LOAD = SUPPLY_CYCLES[21:0];
  localparam int          MCD_INT     = `RSQ_MCD_TIMEOUT_US * (`RSQ_CLK_HZ / 1000000);
  localparam logic [11:0] MCD_CYCLES  = MCD_INT[11:0];

  logic [21:0] supply_cnt;
  logic [21:0] next_supply_cnt;
  logic [3:0]  pin_cnt;
  logic [3:0]  next_pin_cnt;
  logic [11:0] mcd_cnt;
  logic [11:0] next_mcd_cnt;
  logic        next_supply_hold;
  logic        next_pin_hold;
  logic        next_mcd_fire;
  logic        pin_low;

  always_comb begin
    // pin low only counts when nobody inside is pulling it
    pin_low = !rst_pin_in && !pin_driven_in;
    next_supply_cnt = supply_cnt;
    if (!monitor_en_in) begin
      next_supply_cnt = 22'h0;
    end else if (!supply_ok_in) begin
      next_supply_cnt = SUPPLY_LOAD; // R11
    end else if (supply_cnt != 22'h0) begin
      next_supply_cnt = supply_cnt - 22'h1; // R9
    end
    next_supply_hold = monitor_en_in && (!supply_ok_in || next_supply_cnt != 22'h0); // R9
    next_pin_cnt = pin_cnt;
    if (pin_low) begin
      next_pin_cnt = `RSQ_PIN_STRETCH_CYCLES; // R12
    end else if (pin_cnt != 4'h0) begin
      next_pin_cnt = pin_cnt - 4'h1;
    end
    next_pin_hold = pin_low || next_pin_cnt != 4'h0; // R12
    // ticks only clear the count while the oscillator runs, so stop mode runs the detector out
    next_mcd_cnt = mcd_cnt;
    if (!sig.mcd_en || (sysclk_tick_in && sig.osc_run)) begin
      next_mcd_cnt = 12'h0;
    end else if (mcd_cnt != MCD_CYCLES) begin
      next_mcd_cnt = mcd_cnt + 12'h1;
    end
    next_mcd_fire = sig.mcd_en && next_mcd_cnt == MCD_CYCLES; // R13
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      supply_cnt      <= SUPPLY_LOAD;
      pin_cnt         <= 4'h0;
      mcd_cnt         <= 12'h0;
      sig.supply_hold <= 1'b1;
      sig.pin_hold    <= 1'b0;
      sig.mcd_fire    <= 1'b0;
    end else begin
      supply_cnt      <= next_supply_cnt;
      pin_cnt         <= next_pin_cnt;
      mcd_cnt         <= next_mcd_cnt;
      sig.supply_hold <= next_supply_hold;
      sig.pin_hold    <= next_pin_hold;
      sig.mcd_fire    <= next_mcd_fire;
    end
  end
endmodule // rsq_src

// File: tb/rsq_far_model.sv
// far side of the sequencer: reset pin wiring and the system clock activity ticks
// assumes the bench asks for pin pulls and that the pin has a pull-up
`timescale 1ns/1ps
module rsq_far_model (
  input  wire logic clk_in,
  input  wire logic oe_in,
  input  wire logic pull_low_in,
  output logic      pin_out,
  output logic      tick_out
);
  logic [1:0] cnt = 2'h0;
  // pull-up wins only when neither party pulls the pin low
  assign pin_out = !(oe_in || pull_low_in);
  assign tick_out = (cnt == 2'h0);
  always_ff @(posedge clk_in) begin
    cnt <= (cnt == 2'h2) ? 2'h0 : cnt + 2'h1;
  end
endmodule // rsq_far_model

// File: tb/rsq_top_asserts.sv
// timing checks on the sequencer top ports
// assumes bind onto rsq_top
`timescale 1ns/1ps
module rsq_top_asserts (
  input wire logic        REF_CLK_IN,
  input wire logic        RESETN_IN,
  input wire logic [9:0]  AVS_ADDRESS_IN,
  input wire logic        AVS_READ_IN,
  input wire logic        AVS_WRITE_IN,
  input wire logic [31:0] AVS_WRITEDATA_IN,
  input wire logic [3:0]  AVS_BYTEENABLE_IN,
  input wire logic [31:0] AVS_READDATA_OUT,
  input wire logic        AVS_WAITREQUEST_OUT,
  input wire logic        RST_PIN_IN,
  input wire logic        RST_PIN_OUT,
  input wire logic        RST_PIN_OE_OUT,
  input wire logic        CORE_RESET_OUT,
  input wire logic        CPU_HALT_OUT,
  input wire logic        OSC_ENABLE_OUT,
  input wire logic        OSC_DEFAULT_OUT,
  input wire logic        PORT_LATCH_LOAD_OUT,
  input wire logic [7:0]  PORT_LATCH_VALUE_OUT,
  input wire logic        PC_LOAD_OUT,
  input wire logic [15:0] FETCH_ADDR_OUT,
  input wire logic        WDT_ENABLE_OUT,
  input wire logic [2:0]  WDT_INTERVAL_OUT,
  input wire logic        IDLE_WAKE_OUT
);
  default clocking @(posedge REF_CLK_IN); endclocking
  default disable iff (!RESETN_IN);
  port_latch_a: assert property (PORT_LATCH_LOAD_OUT == CORE_RESET_OUT && PORT_LATCH_VALUE_OUT == 8'hff)
    else $error("port latch load wrong");
  halt_in_reset_a: assert property (CORE_RESET_OUT |-> CPU_HALT_OUT && OSC_DEFAULT_OUT)
    else $error("reset without halt");
  boot_pulse_a: assert property (PC_LOAD_OUT |-> WDT_ENABLE_OUT && FETCH_ADDR_OUT == 16'h0000
    && WDT_INTERVAL_OUT == 3'h7 && !CORE_RESET_OUT ##1 !PC_LOAD_OUT) else $error("boot pulse wrong");
  stop_entry_a: assert property (AVS_WRITE_IN && !AVS_WAITREQUEST_OUT && AVS_ADDRESS_IN == 10'h21c
    && AVS_BYTEENABLE_IN[0] && AVS_WRITEDATA_IN[1] && !CPU_HALT_OUT |-> ##2 !OSC_ENABLE_OUT && CPU_HALT_OUT)
    else $error("stop not entered");
  stop_hold_a: assert property (!OSC_ENABLE_OUT |=> !OSC_ENABLE_OUT || CORE_RESET_OUT)
    else $error("stop left without reset");
  power_control_zero_a: assert property (AVS_READ_IN && !AVS_WAITREQUEST_OUT && AVS_ADDRESS_IN == 10'h21c
    |-> AVS_READDATA_OUT[1:0] == 2'b00 && AVS_READDATA_OUT[31:8] == 24'h0) else $error("mode bits read one");
  idle_wake_a: assert property (IDLE_WAKE_OUT |-> !CPU_HALT_OUT ##1 !IDLE_WAKE_OUT)
    else $error("idle wake wrong");
  pin_drive_a: assert property (RST_PIN_OE_OUT |-> !RST_PIN_OUT ##[0:1] CORE_RESET_OUT)
    else $error("pin driven without reset");
  pin_stretch_a: assert property ($rose(RST_PIN_IN) && CORE_RESET_OUT && !$past(RST_PIN_OE_OUT)
    |-> CORE_RESET_OUT [*8]) else $error("pin reset too short");
  one_wait_a: assert property ((AVS_READ_IN || AVS_WRITE_IN) && AVS_WAITREQUEST_OUT |=> !AVS_WAITREQUEST_OUT)
    else $error("bus answer late");
  stop_c: cover property (!OSC_ENABLE_OUT ##1 CORE_RESET_OUT);
  wake_c: cover property (IDLE_WAKE_OUT);
  boot_c: cover property (PC_LOAD_OUT);
endmodule // rsq_top_asserts
bind rsq_top rsq_top_asserts i_rsq_top_asserts (.*);

// File: tb/rsq_top_test.sv
// self-checking bench for the reset and stop-mode sequencer
// assumes a short supply timeout parameter and the far model in rsq_far_model
`timescale 1ns/1ps
module rsq_top_test;
  localparam int SUP = 20;
  localparam logic [9:0] POWER_CONTROL = 10'h21c;
  localparam logic [9:0] CAUSE = 10'h3bc;
  logic clk = 0, rstn = 0, rd = 0, wr = 0, wreq, sup_ok = 1, mon_en = 1, pin_in, pin_out, pin_oe, tick;
  logic cnv = 1, osc_st = 1, irq = 0, core_rst, halt, osc_en, osc_def, pl_load, pc_load, wdt_en, wake, pull = 0;
  logic [9:0] addr = 0;
  logic [31:0] wdata = 0, rdata, rv;
  logic [3:0] be = 0;
  logic [7:0] cp = 8'h80, cn = 8'h10, pl_val;
  logic [15:0] fetch;
  logic [2:0] wdt_iv;
  int err_total = 0, checked = 0, seed = 29133, exp_power_control = 0, n, b;

  initial forever #20 clk = ~clk;

  rsq_top #(.SUPPLY_CYCLES(SUP)) i_rsq_top (.REF_CLK_IN(clk), .RESETN_IN(rstn), .AVS_ADDRESS_IN(addr),
    .AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wdata), .AVS_BYTEENABLE_IN(be),
    .AVS_READDATA_OUT(rdata), .AVS_WAITREQUEST_OUT(wreq), .SUPPLY_OK_IN(sup_ok),
    .SUPPLY_MONITOR_ENABLE_PIN_IN(mon_en), .RST_PIN_IN(pin_in), .RST_PIN_OUT(pin_out), .RST_PIN_OE_OUT(pin_oe),
    .SYSCLK_TICK_IN(tick), .COMPARATOR_NONINVERTING_INPUT_IN(cp), .COMPARATOR_INVERTING_INPUT_IN(cn),
    .CONVERT_START_INPUT_IN(cnv), .OSC_STABLE_IN(osc_st), .IRQ_PENDING_IN(irq), .CORE_RESET_OUT(core_rst),
    .CPU_HALT_OUT(halt), .OSC_ENABLE_OUT(osc_en), .OSC_DEFAULT_OUT(osc_def), .PORT_LATCH_LOAD_OUT(pl_load),
    .PORT_LATCH_VALUE_OUT(pl_val), .PC_LOAD_OUT(pc_load), .FETCH_ADDR_OUT(fetch), .WDT_ENABLE_OUT(wdt_en),
    .WDT_INTERVAL_OUT(wdt_iv), .IDLE_WAKE_OUT(wake));
  rsq_far_model i_rsq_far_model (.clk_in(clk), .oe_in(pin_oe), .pull_low_in(pull), .pin_out(pin_in),
    .tick_out(tick));

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // request held until the edge that samples waitrequest low; read data taken at that edge.
  // right after the edge the design's outputs still show the values that stood at it
  task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] d, input logic [3:0] bm);
    int k;
    k = 0;
    @(posedge clk);
    addr  <= a;
    wdata <= {24'h0, d};
    be    <= bm;
    rd    <= !w;
    wr    <= w;
    @(posedge clk);
    while (wreq !== 1'b0 && k < 50) begin
      @(posedge clk);
      k++;
    end
    chk("bus answer", 1, k < 50);
    rv = rdata;
    rd <= 0;
    wr <= 0;
  endtask

  task automatic rdc(input string what, input logic [9:0] a, input logic [7:0] exp);
    bus(0, a, 8'h00, 4'h0);
    chk(what, {24'h0, exp}, rv);
  endtask

  function automatic logic pick(input int w);
    case (w)
      0: return pc_load;
      1: return core_rst;
      2: return wake;
      default: return !pin_oe;
    endcase
  endfunction

  // counts negedges until the chosen output goes high, or for choice 3 until pin_oe goes low, bounded
  task automatic await(input int w, input int lim);
    n = 0;
    while (pick(w) !== 1'b1 && n < lim) begin
      @(negedge clk);
      n++;
    end
    chk("wait bound", 1, n < lim);
  endtask

  task automatic boot();
    await(0, 300);
    chk("fetch addr", 16'h0000, fetch);
    chk("wdt enable", 1, wdt_en);
    chk("wdt interval", 3'h7, wdt_iv);
    chk("halt at boot", 0, halt);
    exp_power_control = 0;
  endtask

  task automatic wrap_up();
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    #(40 * 20000);
    err_total++;
    wrap_up();
  end

  initial begin
    repeat (6) @(posedge clk);
    rstn <= 1;
    boot();
    rdc("cause after power-on", CAUSE, 8'h02);
    rdc("power_control reset", POWER_CONTROL, 8'h00);
    rdc("unmapped", 10'h000, 8'h00);
    exp_power_control = $random(seed) & 8'hfc;
    bus(1, POWER_CONTROL, exp_power_control[7:0], 4'h1);
    bus(1, POWER_CONTROL, 8'h00, 4'h0);
    rdc("power_control upper", POWER_CONTROL, exp_power_control[7:0]);
    bus(1, POWER_CONTROL, exp_power_control[7:0] | 8'h01, 4'h1);
    repeat (2) @(negedge clk);
    chk("idle halt", 1, halt);
    @(posedge clk) irq <= 1;
    await(2, 20);
    chk("idle resume", 0, halt);
    @(posedge clk) irq <= 0;
    rdc("power_control after idle", POWER_CONTROL, exp_power_control[7:0]);
    // analog blocks are assumed already off; detector stays on so it ends the stop
    bus(1, CAUSE, 8'h04, 4'h1);
    bus(1, POWER_CONTROL, 8'h02, 4'h1);
    repeat (2) @(negedge clk);
    chk("stop osc", 0, osc_en);
    chk("stop halt", 1, halt);
    await(1, 3000);
    chk("clock loss pin", 0, pin_oe);
    boot();
    rdc("cause clock loss", CAUSE, 8'h04);
    rdc("power_control defaults", POWER_CONTROL, 8'h00);
    for (int i = 0; i < 2; i++) begin
      b = i ? 6 : 5;
      @(posedge clk);
      cp <= 8'($random(seed)) & 8'h7f;
      cn <= 8'h80 | 8'($random(seed));
      cnv <= 0;
      repeat (10) @(negedge clk);
      chk("disabled source", 0, core_rst);
      @(posedge clk);
      cp <= 8'h80 | 8'($random(seed));
      cn <= 8'($random(seed)) & 8'h7f;
      cnv <= 1;
      // comparator and routing are set up before the source is enabled
      bus(1, CAUSE, 8'h01 << b, 4'h1);
      @(posedge clk);
      if (b == 5) begin
        cp <= 8'($random(seed)) & 8'h7f;
        cn <= 8'h80 | 8'($random(seed));
      end else
        cnv <= 0;
      await(1, 10);
      chk("port latch load", 1, pl_load);
      chk("port latch value", 8'hff, pl_val);
      chk("osc default", 1, osc_def);
      chk("source pin", 0, pin_oe);
      @(posedge clk);
      cp <= 8'h80 | 8'($random(seed));
      cnv <= 1;
      boot();
      rdc("cause source", CAUSE, 8'h01 << b);
    end
    @(posedge clk) pull <= 1;
    repeat (3) @(negedge clk);
    chk("pin reset", 1, core_rst);
    @(posedge clk) pull <= 0;
    n = 0;
    while (core_rst === 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    chk("pin stretch", 1, n >= 12);
    boot();
    rdc("cause pin", CAUSE, 8'h01);
    @(posedge clk) sup_ok <= 0;
    repeat (4) @(negedge clk);
    chk("supply drive", 1, pin_oe);
    chk("supply pin", 0, pin_in);
    chk("supply pin level", 0, pin_out);
    chk("supply core", 1, core_rst);
    @(posedge clk) sup_ok <= 1;
    await(3, 100);
    chk("supply timeout", 1, n >= SUP && n <= SUP + 3);
    boot();
    rdc("cause supply", CAUSE, 8'h02);
    // with the monitor pin low a supply drop must neither reset nor pull the pin
    @(posedge clk);
    mon_en <= 0;
    sup_ok <= 0;
    repeat (5) @(negedge clk);
    chk("monitor off core", 0, core_rst);
    chk("monitor off pin", 0, pin_oe);
    @(posedge clk);
    sup_ok <= 1;
    mon_en <= 1;
    repeat (3) @(negedge clk);
    chk("monitor back on", 0, core_rst);
    wrap_up();
  end
endmodule // rsq_top_test
